// ===== hw/gpio_sense_latch_port.v
// GPIO port with per-pin configuration, level sensing, sticky sense flags and an APB register slave.
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "gpio_sense_consts.vh"

module gpio_sense_latch_port
#(
  parameter NUM_PINS = 32
)
(
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pad side
  input wire [NUM_PINS-1:0] pin_in,
  output reg [NUM_PINS-1:0] pin_out,
  output reg [NUM_PINS-1:0] pin_oe,
  output reg [NUM_PINS-1:0] pin_in_enable,
  output reg [NUM_PINS-1:0] pin_pull_up,
  output reg [NUM_PINS-1:0] pin_pull_down,
  output reg [NUM_PINS-1:0] pin_high_drive0,
  output reg [NUM_PINS-1:0] pin_high_drive1,
  // Peripheral override
  input wire [NUM_PINS-1:0] periph_take,
  input wire [NUM_PINS-1:0] periph_out,
  input wire [NUM_PINS-1:0] periph_oe,
  output reg [NUM_PINS-1:0] periph_in,
  // Detect outputs
  output reg [NUM_PINS-1:0] level_detect,
  output reg latched_detect,
  output reg port_detect,
  output reg port_change_event
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------

  // True when the address selects one of the pin_config words.
  function is_config;
    input [`ADDR_W-1:0] addr;
    begin
      is_config = (addr >= `OFS_PIN_CONFIG_BASE) && (addr <= `OFS_PIN_CONFIG_LAST) && (addr[1:0] == 2'h0);
    end
  endfunction

  // Pin index of a pin_config address.
  function [4:0] config_index;
    input [`ADDR_W-1:0] addr;
    reg [`ADDR_W-1:0] diff;
    begin
      diff = addr - `OFS_PIN_CONFIG_BASE;
      config_index = diff[6:2];
    end
  endfunction

  // True when the address is a mapped register.
  function is_mapped;
    input [`ADDR_W-1:0] addr;
    begin
      case (addr)
        `OFS_OUT_VALUE, `OFS_OUT_SET, `OFS_OUT_CLEAR, `OFS_IN_VALUE, `OFS_DIR_VALUE, `OFS_DIR_SET,
        `OFS_DIR_CLEAR, `OFS_SENSE_LATCH_FLAGS, `OFS_DETECT_SOURCE_SELECT:
          is_mapped = 1'b1;
        default:
          is_mapped = is_config(addr) && (config_index(addr) < NUM_PINS);
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------

  reg [NUM_PINS-1:0] out_value;
  reg [NUM_PINS-1:0] dir_value;
  reg [NUM_PINS-1:0] sense_latch_flags;
  reg detect_source_select;
  reg [31:0] pin_config [0:NUM_PINS-1];

  reg [NUM_PINS-1:0] sync1;
  reg [NUM_PINS-1:0] sync2;
  reg [NUM_PINS-1:0] sync3;
  reg [NUM_PINS-1:0] in_value;

  wire [NUM_PINS-1:0] pin_connected;
  wire [NUM_PINS-1:0] next_level_detect;
  wire [NUM_PINS-1:0] pin_dir;
  wire [NUM_PINS-1:0] next_pin_oe;
  wire [NUM_PINS-1:0] next_pin_out;
  wire [NUM_PINS-1:0] cfg_high0;
  wire [NUM_PINS-1:0] cfg_high1;
  wire [NUM_PINS-1:0] cfg_pull_up;
  wire [NUM_PINS-1:0] cfg_pull_down;

  wire access = psel && penable;
  wire write_now = access && pready && pwrite;
  wire latch_clear_write = write_now && (paddr == `OFS_SENSE_LATCH_FLAGS);

  // ---------------------------------------------------------------
  // Input synchroniser
  // ---------------------------------------------------------------

  // Three stages; the settled value moves only once stages two and three agree.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= {NUM_PINS{1'b0}};
      sync2 <= {NUM_PINS{1'b0}};
      sync3 <= {NUM_PINS{1'b0}};
      in_value <= {NUM_PINS{1'b0}};
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      in_value <= (sync2 & sync3) | (in_value & (sync2 | sync3));
    end
  end

  // ---------------------------------------------------------------
  // Per-pin configuration decode
  // ---------------------------------------------------------------

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : pin_slice
      wire [31:0] cfg = pin_config[g];
      wire [1:0] sense = cfg[`CFG_SENSE_MSB:`CFG_SENSE_LSB];
      wire [2:0] drive = cfg[`CFG_DRIVE_MSB:`CFG_DRIVE_LSB];
      wire [1:0] pull = cfg[`CFG_PULL_MSB:`CFG_PULL_LSB];
      wire own_oe;
      assign pin_connected[g] = ~cfg[`CFG_DISCONNECT_BIT];
      assign pin_dir[g] = dir_value[g];
      // Sensing sees only a connected input; any other sense code disables it.
      assign next_level_detect[g] = pin_connected[g] &&
        (((sense == `SENSE_HIGH) && in_value[g]) || ((sense == `SENSE_LOW) && !in_value[g]));
      // Drive codes 4 and 5 release the low level, 6 and 7 release the high level.
      assign own_oe = pin_dir[g] && !((drive[2:1] == 2'h2) && !out_value[g]) &&
        !((drive[2:1] == 2'h3) && out_value[g]);
      assign next_pin_oe[g] = periph_take[g] ? periph_oe[g] : own_oe;
      assign next_pin_out[g] = periph_take[g] ? periph_out[g] : out_value[g];
      assign cfg_high0[g] = (drive == 3'h1) || (drive == 3'h3) || (drive == 3'h7);
      assign cfg_high1[g] = (drive == 3'h2) || (drive == 3'h3) || (drive == 3'h5);
      assign cfg_pull_up[g] = (pull == `PULL_UP);
      assign cfg_pull_down[g] = (pull == `PULL_DOWN);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pad and peripheral outputs
  // ---------------------------------------------------------------

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= {NUM_PINS{1'b0}};
      pin_oe <= {NUM_PINS{1'b0}};
      pin_in_enable <= {NUM_PINS{1'b0}};
      pin_pull_up <= {NUM_PINS{1'b0}};
      pin_pull_down <= {NUM_PINS{1'b0}};
      pin_high_drive0 <= {NUM_PINS{1'b0}};
      pin_high_drive1 <= {NUM_PINS{1'b0}};
      periph_in <= {NUM_PINS{1'b0}};
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      pin_in_enable <= pin_connected;
      pin_pull_up <= cfg_pull_up;
      pin_pull_down <= cfg_pull_down;
      pin_high_drive0 <= cfg_high0;
      pin_high_drive1 <= cfg_high1;
      periph_in <= in_value & pin_connected;
    end
  end

  // ---------------------------------------------------------------
  // Detect, sticky flags and port detect
  // ---------------------------------------------------------------

  // Clear requests drop only for bits whose detect is low; a new detect wins over a clear.
  wire [NUM_PINS-1:0] clear_mask = latch_clear_write ? pwdata[NUM_PINS-1:0] : {NUM_PINS{1'b0}};
  wire [NUM_PINS-1:0] detect_rise = next_level_detect & ~level_detect;
  wire [NUM_PINS-1:0] next_flags = (sense_latch_flags & ~(clear_mask & ~level_detect)) | detect_rise;
  // A clear write forces one low cycle so remaining flags give a new rising edge.
  wire next_latched = (|next_flags) && !latch_clear_write;
  wire next_port_detect = detect_source_select ? latched_detect : (|level_detect);

  // Nothing here is gated by the sleep state, so wake-up works in deep sleep.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_detect <= {NUM_PINS{1'b0}};
      sense_latch_flags <= {NUM_PINS{1'b0}};
      latched_detect <= 1'b0;
      port_detect <= 1'b0;
      port_change_event <= 1'b0;
    end
    else
    begin
      level_detect <= next_level_detect;
      sense_latch_flags <= next_flags;
      latched_detect <= next_latched;
      port_detect <= next_port_detect;
      port_change_event <= next_port_detect && !port_detect;
    end
  end

  // ---------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------

  // pin_config is reset only by presetn, which the power manager keeps high through
  // low-power states, so its contents are retained.
  integer i;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_value <= {NUM_PINS{1'b0}};
      dir_value <= {NUM_PINS{1'b0}};
      detect_source_select <= 1'b0;
      for (i = 0; i < NUM_PINS; i = i + 1)
      begin
        pin_config[i] <= `PIN_CONFIG_RESET;
      end
    end
    else if (write_now)
    begin
      case (paddr)
        `OFS_OUT_VALUE:
          out_value <= pwdata[NUM_PINS-1:0];
        `OFS_OUT_SET:
          out_value <= out_value | pwdata[NUM_PINS-1:0];
        `OFS_OUT_CLEAR:
          out_value <= out_value & ~pwdata[NUM_PINS-1:0];
        `OFS_DIR_VALUE:
          dir_value <= pwdata[NUM_PINS-1:0];
        `OFS_DIR_SET:
          dir_value <= dir_value | pwdata[NUM_PINS-1:0];
        `OFS_DIR_CLEAR:
          dir_value <= dir_value & ~pwdata[NUM_PINS-1:0];
        `OFS_DETECT_SOURCE_SELECT:
          detect_source_select <= pwdata[0];
        default:
        begin
          if (is_mapped(paddr) && is_config(paddr))
          begin
            pin_config[config_index(paddr)] <= pwdata & `PIN_CONFIG_MASK;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------

  reg [31:0] read_word;
  always @*
  begin
    read_word = 32'h00000000;
    case (paddr)
      `OFS_OUT_VALUE, `OFS_OUT_SET, `OFS_OUT_CLEAR:
        read_word[NUM_PINS-1:0] = out_value;
      `OFS_IN_VALUE:
        read_word[NUM_PINS-1:0] = in_value & pin_connected;
      `OFS_DIR_VALUE, `OFS_DIR_SET, `OFS_DIR_CLEAR:
        read_word[NUM_PINS-1:0] = dir_value;
      `OFS_SENSE_LATCH_FLAGS:
        read_word[NUM_PINS-1:0] = sense_latch_flags;
      `OFS_DETECT_SOURCE_SELECT:
        read_word[0] = detect_source_select;
      default:
      begin
        if (is_mapped(paddr) && is_config(paddr))
        begin
          read_word = pin_config[config_index(paddr)];
        end
      end
    endcase
  end

  // One wait state: data and error are captured in the first access cycle,
  // pready rises in the second, when the write also takes effect.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= access && !pready;
      if (access && !pready)
      begin
        pslverr <= !is_mapped(paddr);
        prdata <= (pwrite || !is_mapped(paddr)) ? 32'h00000000 : read_word;
      end
      else
      begin
        pslverr <= 1'b0;
      end
    end
  end

endmodule

// ===== pkg/gpio_sense_consts.vh
// Register offsets, field positions, reset values and codes of the sense-latch GPIO port.
`ifndef GPIO_SENSE_CONSTS_VH
`define GPIO_SENSE_CONSTS_VH

`define ADDR_W 12
`define OFS_OUT_VALUE 12'h504
`define OFS_OUT_SET 12'h508
`define OFS_OUT_CLEAR 12'h50c
`define OFS_IN_VALUE 12'h510
`define OFS_DIR_VALUE 12'h514
`define OFS_DIR_SET 12'h518
`define OFS_DIR_CLEAR 12'h51c
`define OFS_SENSE_LATCH_FLAGS 12'h520
`define OFS_DETECT_SOURCE_SELECT 12'h524
`define OFS_PIN_CONFIG_BASE 12'h700
`define OFS_PIN_CONFIG_LAST 12'h77c

`define PIN_CONFIG_RESET 32'h00000002
`define PIN_CONFIG_MASK 32'h0003070f
`define CFG_DIR_BIT 0
`define CFG_DISCONNECT_BIT 1
`define CFG_PULL_LSB 2
`define CFG_PULL_MSB 3
`define CFG_DRIVE_LSB 8
`define CFG_DRIVE_MSB 10
`define CFG_SENSE_LSB 16
`define CFG_SENSE_MSB 17

`define PULL_DOWN 2'h1
`define PULL_UP 2'h3
`define SENSE_HIGH 2'h2
`define SENSE_LOW 2'h3

`endif

// ===== sim/gpio_sense_latch_port_properties.sv
// Concurrent checks on the ports of the sense-latch GPIO port.
`timescale 1ns/1ps
`include "gpio_sense_consts.vh"
module gpio_sense_checker
#(
  parameter NUM_PINS = 32
)
(
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire [`ADDR_W-1:0] paddr,
  // Pads and override
  input wire [NUM_PINS-1:0] pin_out,
  input wire [NUM_PINS-1:0] pin_in_enable,
  input wire [NUM_PINS-1:0] pin_pull_up,
  input wire [NUM_PINS-1:0] pin_pull_down,
  input wire [NUM_PINS-1:0] periph_take,
  input wire [NUM_PINS-1:0] periph_out,
  // Detects
  input wire [NUM_PINS-1:0] level_detect,
  input wire latched_detect,
  input wire port_detect,
  input wire port_change_event
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_pull_excl;
    ~|(pin_pull_up & pin_pull_down);
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_port_src;
    port_detect == $past(|level_detect) || port_detect == $past(latched_detect);
  endproperty
  a_port_src: assert property (p_port_src) else $error("port detect from no source");
  property p_event;
    $rose(port_detect) |-> ##[0:1] port_change_event;
  endproperty
  a_event: assert property (p_event) else $error("no port event");
  property p_flag_set;
    |(level_detect & ~$past(level_detect)) |-> ##[0:2] latched_detect;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("latched detect missing");
  property p_fall_cause;
    $fell(latched_detect) |-> $past(psel && penable && pready && pwrite && paddr == `OFS_SENSE_LATCH_FLAGS);
  endproperty
  a_fall_cause: assert property (p_fall_cause) else $error("latched detect fell without clear");
  property p_fresh_edge;
    $fell(latched_detect) && |$past(level_detect) |=> latched_detect;
  endproperty
  a_fresh_edge: assert property (p_fresh_edge) else $error("no fresh latched edge");
  property p_disc;
    ~|(level_detect & ~(pin_in_enable | $past(pin_in_enable) | $past(pin_in_enable, 2) |
      $past(pin_in_enable, 3) | $past(pin_in_enable, 4) | $past(pin_in_enable, 5)));
  endproperty
  a_disc: assert property (p_disc) else $error("detect on disconnected pin");
  property p_take;
    ~|((pin_out ^ $past(periph_out)) & $past(periph_take));
  endproperty
  a_take: assert property (p_take) else $error("override output ignored");
endmodule

bind gpio_sense_latch_port gpio_sense_checker #(.NUM_PINS(NUM_PINS)) gpio_sense_checker_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .paddr, .pin_out, .pin_in_enable, .pin_pull_up, .pin_pull_down,
  .periph_take, .periph_out, .level_detect, .latched_detect, .port_detect, .port_change_event);

// ===== sim/gpio_sense_latch_port_tb.sv
// Self-checking bench of the sense-latch GPIO port.
`timescale 1ns/1ps
`include "gpio_sense_consts.vh"
module gpio_sense_latch_port_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, latched_detect, port_detect, port_change_event;
  logic [`ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pin_in_enable, pin_pull_up, pin_pull_down;
  logic [31:0] periph_take, periph_out, periph_oe, periph_in, level_detect, ext_en, ext_val;
  logic [31:0] pin_high_drive0, pin_high_drive1;
  logic [31:0] rdat, rerr, seed, exp_flags, exp_out, exp_dir, ra, rb, rc;
  integer mismatches, num_checks, cyc = 0, p, q, i;
  gpio_sense_latch_port gpio_sense_latch_port_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_in_enable, .pin_pull_up, .pin_pull_down,
    .pin_high_drive0, .pin_high_drive1, .periph_take, .periph_out, .periph_oe, .periph_in,
    .level_detect, .latched_detect, .port_detect, .port_change_event);
  pin_partner pin_partner_i (.pclk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_en, .ext_val, .pin_in);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      wrap_up;
    end
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wdet(input integer n, input logic e);
    for (int k = 0; k < 12 && level_detect[n] !== e; k++)
      @(posedge pclk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {mismatches, num_checks, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {periph_take, periph_out, periph_oe, ext_val, exp_flags} = '0;
    ext_en = '1;
    seed = 32'h1a1199c9;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    p = rnd() % 32;
    q = (p + 1 + rnd() % 31) % 32;
    apb(0, 12'(`OFS_PIN_CONFIG_BASE + p * 4), 0);
    chk(rdat, `PIN_CONFIG_RESET);
    apb(0, `OFS_DETECT_SOURCE_SELECT, 0);
    chk(rdat, 0);
    apb(0, 12'h600, 0);
    chk(rerr, 1);
    $display("test reset done");
    apb(1, 12'(`OFS_PIN_CONFIG_BASE + p * 4), 32'h00020000);
    wdet(p, 1'b1);
    chk(level_detect[p], 1'b0);
    ext_val[p] <= 1'b1;
    wdet(p, 1'b1);
    chk(level_detect[p], 1'b1);
    exp_flags[p] = 1'b1;
    apb(0, `OFS_SENSE_LATCH_FLAGS, 0);
    chk(rdat, exp_flags);
    apb(1, `OFS_SENSE_LATCH_FLAGS, 32'h1 << p);
    apb(0, `OFS_SENSE_LATCH_FLAGS, 0);
    chk(rdat, exp_flags);
    ext_val[p] <= 1'b0;
    wdet(p, 1'b0);
    apb(0, `OFS_SENSE_LATCH_FLAGS, 0);
    chk(rdat, exp_flags);
    apb(1, `OFS_SENSE_LATCH_FLAGS, 32'h1 << p);
    exp_flags[p] = 1'b0;
    apb(0, `OFS_SENSE_LATCH_FLAGS, 0);
    chk(rdat, exp_flags);
    $display("test sense high done");
    apb(1, 12'(`OFS_PIN_CONFIG_BASE + q * 4), 32'h00030000);
    wdet(q, 1'b1);
    chk(level_detect[q], 1'b1);
    exp_flags[q] = 1'b1;
    apb(1, `OFS_DETECT_SOURCE_SELECT, 1);
    ext_val[q] <= 1'b1;
    wdet(q, 1'b0);
    repeat (3) @(posedge pclk);
    chk(port_detect, 1'b1);
    apb(0, `OFS_SENSE_LATCH_FLAGS, 0);
    chk(rdat, exp_flags);
    apb(1, `OFS_SENSE_LATCH_FLAGS, 32'h1 << q);
    exp_flags[q] = 1'b0;
    repeat (3) @(posedge pclk);
    chk(port_detect, 1'b0);
    apb(1, `OFS_DETECT_SOURCE_SELECT, 0);
    ext_val[q] <= 1'b0;
    wdet(q, 1'b1);
    repeat (2) @(posedge pclk);
    chk(port_detect, 1'b1);
    ext_val[q] <= 1'b1;
    wdet(q, 1'b0);
    repeat (2) @(posedge pclk);
    chk(port_detect, 1'b0);
    apb(1, `OFS_SENSE_LATCH_FLAGS, 32'h1 << q);
    $display("test detect source done");
    apb(1, 12'(`OFS_PIN_CONFIG_BASE + p * 4), 32'h00020002);
    ext_val[p] <= 1'b1;
    wdet(p, 1'b1);
    chk(level_detect[p], 1'b0);
    chk(pin_in_enable[p], 1'b0);
    apb(0, `OFS_IN_VALUE, 0);
    chk(rdat[p], 1'b0);
    chk(periph_in[p], 1'b0);
    apb(1, 12'(`OFS_PIN_CONFIG_BASE + p * 4), 0);
    repeat (6) @(posedge pclk);
    apb(0, `OFS_IN_VALUE, 0);
    chk(rdat[p], 1'b1);
    chk(periph_in[p], 1'b1);
    apb(1, 12'(`OFS_PIN_CONFIG_BASE + p * 4), '1);
    apb(0, 12'(`OFS_PIN_CONFIG_BASE + p * 4), 0);
    chk(rdat, `PIN_CONFIG_MASK);
    chk(pin_pull_up[p], 1'b1);
    chk(pin_pull_down[p], 1'b0);
    chk(pin_high_drive0[p], 1'b1);
    chk(pin_high_drive1[p], 1'b0);
    $display("test input path done");
    for (i = 0; i < 2; i++)
    begin
      ra = rnd();
      rb = rnd();
      rc = rnd();
      apb(1, 12'(`OFS_OUT_VALUE + i * 16), ra);
      apb(1, 12'(`OFS_OUT_SET + i * 16), rb);
      apb(1, 12'(`OFS_OUT_CLEAR + i * 16), rc);
      apb(0, 12'(`OFS_OUT_SET + i * 16), 0);
      chk(rdat, (ra | rb) & ~rc);
      if (i == 0)
        exp_out = (ra | rb) & ~rc;
      else
        exp_dir = (ra | rb) & ~rc;
    end
    chk(pin_out, exp_out);
    chk(pin_oe, exp_dir & ~(exp_out & (32'h1 << p)));
    periph_take <= rnd();
    periph_out <= rnd();
    periph_oe <= rnd();
    repeat (2) @(posedge pclk);
    chk((pin_out ^ periph_out) & periph_take, 0);
    chk((pin_oe ^ periph_oe) & periph_take, 0);
    chk(pin_out & ~periph_take, exp_out & ~periph_take);
    $display("test outputs done");
    wrap_up;
  end
endmodule

// ===== sim/pin_partner.sv
// Board circuitry model that drives and senses the port pins.
`timescale 1ns/1ps
module pin_partner
(
  // Clock
  input wire pclk,
  // Pad side of the port
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe,
  input wire [31:0] pin_pull_up,
  input wire [31:0] pin_pull_down,
  // Board drive commanded by the bench
  input wire [31:0] ext_en,
  input wire [31:0] ext_val,
  output logic [31:0] pin_in
);
  logic [31:0] noise = 32'h0;
  // A floating pin wanders every cycle, so synchroniser stages two and three never agree and in_value keeps its last level.
  always @(posedge pclk)
    noise <= ~noise;
  always_comb
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
      (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & noise)));
endmodule
